// ==== tcfg_pkg.sv ====
// shared constants for the timing configuration packet link
package tcfg_pkg;
  localparam logic [7:0]  START_BYTE   = 8'h10;
  localparam logic [7:0]  PKT_ID       = 8'h91;
  localparam logic [7:0]  SUB_ID       = 8'h03;
  localparam logic [7:0]  END_BYTE     = 8'h03;
  localparam logic [7:0]  MODE_QUERY   = 8'h00;
  localparam logic [7:0]  MODE_SET     = 8'h01;
  localparam logic [7:0]  MODE_RESP    = 8'h02;
  localparam logic [15:0] LEN_QUERY    = 16'h0002;
  localparam logic [15:0] LEN_SET      = 16'h0013;
  localparam int          PAY_BYTES    = 17;
  localparam int          QUERY_TOTAL  = 9;
  localparam int          SET_TOTAL    = 26;
  // payload byte indices within the frame
  localparam int          POS_TBASE    = 6;
  localparam int          POS_PBASE    = 7;
  localparam int          POS_MASK     = 8;
  localparam int          POS_WIDTH    = 13;
  localparam int          POS_OFFSET   = 15;
  localparam logic [15:0] WIDTH_MIN    = 16'd1;
  localparam logic [15:0] WIDTH_MAX    = 16'd500;
  localparam logic [2:0]  CONST_MAX    = 3'd4;
  localparam logic [2:0]  PMODE_OFF    = 3'd0;
  localparam logic [2:0]  PMODE_ON     = 3'd1;
  localparam logic [2:0]  PMODE_FIX    = 3'd2;
  localparam logic [2:0]  PMODE_VALID  = 3'd3;
  // offset 0.25 s as double, and 1 ms
  localparam logic [63:0] OFS_LIMIT    = 64'h3fd0000000000000;
  localparam logic [63:0] MS_ONE       = 64'h3f50624dd2f1a9fc;
  // reset settings: gps, gps, always on, 200 ms
  localparam logic [7:0]  RST_TBASE    = 8'h00;
  localparam logic [7:0]  RST_PBASE    = 8'h00;
  localparam logic [7:0]  RST_MASK     = 8'h01;
  localparam logic [15:0] RST_WIDTH    = 16'd200;
endpackage : tcfg_pkg

// ==== tcfg_if.sv ====
// byte-serial link between host controller and timing device
`timescale 1ns/1ps
interface tcfg_if;
  logic [7:0] h2d_data;
  logic       h2d_valid;
  logic [7:0] d2h_data;
  logic       d2h_valid;
  modport dev  (input h2d_data, input h2d_valid, output d2h_data, output d2h_valid);
  modport host (output h2d_data, output h2d_valid, input d2h_data, input d2h_valid);
endinterface : tcfg_if

// ==== tcfg_device.sv ====
// device end: parses timing configuration packets and answers them
`timescale 1ns/1ps
module tcfg_device
  import tcfg_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // link
  tcfg_if.dev              link,
  // applied settings and frame error flag
  output logic [2:0]       time_constellation,
  output logic             time_utc,
  output logic [2:0]       pulse_constellation,
  output logic             pulse_utc,
  output logic [2:0]       pulse_mode,
  output logic             pulse_negative,
  output logic             even_two_second_pulse,
  output logic [15:0]      pulse_width_ms,
  output logic [63:0]      pulse_offset,
  output logic             frame_error
);
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_BODY = 2'b01,
    RX_TAIL = 2'b10
  } rx_state_t;

  rx_state_t   st_reg, st_next;
  logic [4:0]  idx_reg, idx_next;
  logic [7:0]  buf_reg [0:SET_TOTAL-1];
  logic [7:0]  buf_next[0:SET_TOTAL-1];
  logic [7:0]  sum_reg, sum_next;
  logic [7:0]  tb_reg, tb_next, pb_reg, pb_next, mk_reg, mk_next;
  logic [15:0] wd_reg, wd_next;
  logic [63:0] of_reg, of_next;
  logic        err_reg, err_next;
  logic        tx_go_reg, tx_go_next;
  logic [4:0]  tx_idx_reg, tx_idx_next;
  logic [7:0]  tx_sum_reg, tx_sum_next;
  logic [7:0]  d_reg, d_next;
  logic        v_reg, v_next;
  logic        dv_reg;
  logic        tx_last;
  logic [7:0]  tx_byte;
  logic [15:0] len_rx;
  logic [4:0]  frame_len;
  logic [15:0] w_in;
  logic [63:0] o_in, o_abs;
  logic        w_ok, o_ok;

  // field views of the receive buffer
  // msb first fields
  assign len_rx    = {buf_reg[3], buf_reg[4]};
  assign w_in      = {buf_reg[POS_WIDTH], buf_reg[POS_WIDTH+1]};
  assign o_in      = {buf_reg[15], buf_reg[16], buf_reg[17], buf_reg[18],
                      buf_reg[19], buf_reg[20], buf_reg[21], buf_reg[22]};
  assign o_abs     = {1'b0, o_in[62:0]};
  assign w_ok      = (w_in > WIDTH_MIN) && (w_in <= WIDTH_MAX);
  // positive doubles compare as integers, so magnitude check is exact
  assign o_ok      = (o_abs <= OFS_LIMIT);
  assign frame_len = (len_rx == LEN_SET) ? 5'(SET_TOTAL) : 5'(QUERY_TOTAL);

  // receive parser next state
  always_comb begin
    st_next  = st_reg;
    idx_next = idx_reg;
    sum_next = sum_reg;
    tb_next  = tb_reg;
    pb_next  = pb_reg;
    mk_next  = mk_reg;
    wd_next  = wd_reg;
    of_next  = of_reg;
    err_next = err_reg;
    tx_go_next = tx_go_reg & v_reg;
    for (int i = 0; i < SET_TOTAL; i++) buf_next[i] = buf_reg[i];
    if (link.h2d_valid) begin
      unique case (st_reg)
        RX_IDLE: begin
          if (link.h2d_data == START_BYTE) begin
            st_next  = RX_BODY;
            idx_next = 5'd1;
            sum_next = 8'h00;
          end
        end
        RX_BODY: begin
          buf_next[idx_reg] = link.h2d_data;
          idx_next = idx_reg + 5'd1;
          if (idx_reg < 5'(SET_TOTAL - 3)) sum_next = sum_reg ^ link.h2d_data;
          if ((idx_reg == 5'd1 && link.h2d_data != PKT_ID) ||
              (idx_reg == 5'd2 && link.h2d_data != SUB_ID)) begin
            st_next  = RX_IDLE;
            err_next = 1'b1;
          end else if (idx_reg == 5'd4) begin
            if ({buf_reg[3], link.h2d_data} != LEN_QUERY &&
                {buf_reg[3], link.h2d_data} != LEN_SET) begin
              st_next  = RX_IDLE;
              err_next = 1'b1;
            end
          end else if (idx_reg > 5'd4 && idx_reg == frame_len - 5'd3) begin
            st_next = RX_TAIL;
            // checksum byte: kept aside, never folded into the running sum
            buf_next[0] = link.h2d_data;
            sum_next    = sum_reg;
          end
        end
        RX_TAIL: begin
          idx_next = idx_reg + 5'd1;
          if (idx_reg == frame_len - 5'd2 && link.h2d_data != START_BYTE) begin
            st_next  = RX_IDLE;
            err_next = 1'b1;
          end else if (idx_reg == frame_len - 5'd1) begin
            st_next = RX_IDLE;
            if (link.h2d_data != END_BYTE || buf_reg[0] != sum_reg) begin
              err_next = 1'b1;
            end else if (frame_len == 5'(QUERY_TOTAL) && buf_reg[5] == MODE_QUERY) begin
              tx_go_next = 1'b1;
              err_next   = 1'b0;
            end else if (frame_len == 5'(SET_TOTAL) && buf_reg[5] == MODE_SET &&
                         w_ok && o_ok) begin
              tb_next = {4'h0, buf_reg[POS_TBASE][3:0]};
              pb_next = {4'h0, buf_reg[POS_PBASE][3:0]};
              mk_next = {3'h0, buf_reg[POS_MASK][4:0]};
              wd_next = w_in;
              // offset at or past width zeroed
              of_next = (!o_in[63] && o_ms_ge(o_in, w_in)) ? 64'h0 : o_in;
              tx_go_next = 1'b1;
              err_next   = 1'b0;
            end else begin
              err_next = 1'b1;
            end
          end
        end
        default: st_next = RX_IDLE;
      endcase
    end
  end

  // offset reaches width when offset seconds * 1000 >= width ms;
  // exact on whole ms: floor(mantissa * 1000 / 2^(1075 - exp)) >= width
  function automatic logic o_ms_ge(input logic [63:0] o, input logic [15:0] w);
    logic [11:0] sh;
    logic [63:0] ms;
    // callers pass |offset| <= 0.25 s, so the shift is at least 54
    sh = 12'd1075 - {1'b0, o[62:52]};
    ms = ({11'h0, 1'b1, o[51:0]} * 64'd1000) >> sh;
    return (o[62:52] != 11'h0) && (ms >= {48'h0, w});
  endfunction : o_ms_ge

  // response byte stream, reserved bytes sent as zero
  always_comb begin
    tx_byte = 8'h00;
    unique case (tx_idx_reg)
      5'd0, 5'd24: tx_byte = START_BYTE;
      5'd1:        tx_byte = PKT_ID;
      5'd2:        tx_byte = SUB_ID;
      5'd3:        tx_byte = LEN_SET[15:8];
      5'd4:        tx_byte = LEN_SET[7:0];
      5'd5:        tx_byte = MODE_RESP;
      5'd6:        tx_byte = tb_reg;
      5'd7:        tx_byte = pb_reg;
      5'd8:        tx_byte = mk_reg;
      5'd13:       tx_byte = wd_reg[15:8];
      5'd14:       tx_byte = wd_reg[7:0];
      5'd15:       tx_byte = of_reg[63:56];
      5'd16:       tx_byte = of_reg[55:48];
      5'd17:       tx_byte = of_reg[47:40];
      5'd18:       tx_byte = of_reg[39:32];
      5'd19:       tx_byte = of_reg[31:24];
      5'd20:       tx_byte = of_reg[23:16];
      5'd21:       tx_byte = of_reg[15:8];
      5'd22:       tx_byte = of_reg[7:0];
      5'd23:       tx_byte = tx_sum_reg;
      5'd25:       tx_byte = END_BYTE;
      default:     tx_byte = 8'h00;
    endcase
  end

  // transmitter sequencing
  assign tx_last = (tx_idx_reg == 5'(SET_TOTAL - 1));
  always_comb begin
    tx_idx_next = tx_idx_reg;
    tx_sum_next = tx_sum_reg;
    d_next      = v_reg ? tx_byte : 8'h00;
    v_next      = 1'b0;
    if (tx_go_reg && !v_reg) begin
      tx_idx_next = 5'd0;
      tx_sum_next = 8'h00;
      v_next      = 1'b1;
    end else if (v_reg && !tx_last) begin
      tx_idx_next = tx_idx_reg + 5'd1;
      v_next      = 1'b1;
    end
    if (v_reg && tx_idx_reg >= 5'd1 && tx_idx_reg <= 5'd22) tx_sum_next = tx_sum_reg ^ tx_byte;
  end

  // all state registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg     <= RX_IDLE;
      idx_reg    <= 5'd0;
      sum_reg    <= 8'h00;
      tb_reg     <= RST_TBASE;
      pb_reg     <= RST_PBASE;
      mk_reg     <= RST_MASK;
      wd_reg     <= RST_WIDTH;
      of_reg     <= 64'h0;
      err_reg    <= 1'b0;
      tx_go_reg  <= 1'b0;
      tx_idx_reg <= 5'd0;
      tx_sum_reg <= 8'h00;
      v_reg      <= 1'b0;
      d_reg      <= 8'h00;
      dv_reg     <= 1'b0;
      for (int i = 0; i < SET_TOTAL; i++) buf_reg[i] <= 8'h00;
    end else begin
      st_reg     <= st_next;
      idx_reg    <= idx_next;
      sum_reg    <= sum_next;
      tb_reg     <= tb_next;
      pb_reg     <= pb_next;
      mk_reg     <= mk_next;
      wd_reg     <= wd_next;
      of_reg     <= of_next;
      err_reg    <= err_next;
      tx_go_reg  <= tx_go_next;
      tx_idx_reg <= tx_idx_next;
      tx_sum_reg <= tx_sum_next;
      v_reg      <= v_next;
      d_reg      <= d_next;
      dv_reg     <= v_reg;
      for (int i = 0; i < SET_TOTAL; i++) buf_reg[i] <= buf_next[i];
    end
  end

  // outputs straight from registers
  assign link.d2h_data         = d_reg;
  assign link.d2h_valid        = dv_reg;
  assign time_constellation    = tb_reg[2:0];
  assign time_utc              = tb_reg[3];
  assign pulse_constellation   = pb_reg[2:0];
  assign pulse_utc             = pb_reg[3];
  assign pulse_mode            = mk_reg[2:0];
  assign pulse_negative        = mk_reg[3];
  assign even_two_second_pulse = mk_reg[4];
  assign pulse_width_ms        = wd_reg;
  assign pulse_offset          = of_reg;
  assign frame_error           = err_reg;
endmodule : tcfg_device

// ==== tcfg_host.sv ====
// host end: builds query and set packets for the timing device
`timescale 1ns/1ps
module tcfg_host
  import tcfg_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // link
  tcfg_if.host             link,
  // user request
  input  wire logic        req_query,
  input  wire logic        req_set,
  input  wire logic [7:0]  set_time_base,
  input  wire logic [7:0]  set_pulse_base,
  input  wire logic [7:0]  set_pulse_mask,
  input  wire logic [15:0] set_width_ms,
  input  wire logic [63:0] set_offset,
  // status and echoed response
  output logic             busy,
  output logic             resp_valid,
  output logic [7:0]       resp_byte
);
  logic [4:0]  idx_reg, idx_next;
  logic        act_reg, act_next, qry_reg, qry_next;
  logic [7:0]  sum_reg, sum_next;
  logic [7:0]  d_reg, d_next;
  logic        v_reg, v_next;
  logic [7:0]  tb_reg, pb_reg, mk_reg;
  logic [15:0] wd_reg;
  logic [63:0] of_reg;
  logic [7:0]  rb_reg;
  logic        rv_reg;
  logic [7:0]  byte_c;
  logic [4:0]  last_idx;

  assign last_idx = qry_reg ? 5'(QUERY_TOTAL - 1) : 5'(SET_TOTAL - 1);

  // frame byte for current index, msb first fields
  always_comb begin
    byte_c = 8'h00;
    if (qry_reg) begin
      unique case (idx_reg)
        5'd0, 5'd7: byte_c = START_BYTE;
        5'd1:       byte_c = PKT_ID;
        5'd2:       byte_c = SUB_ID;
        5'd3:       byte_c = LEN_QUERY[15:8];
        5'd4:       byte_c = LEN_QUERY[7:0];
        5'd5:       byte_c = MODE_QUERY;
        5'd6:       byte_c = sum_reg;
        5'd8:       byte_c = END_BYTE;
        default:    byte_c = 8'h00;
      endcase
    end else begin
      unique case (idx_reg)
        5'd0, 5'd24: byte_c = START_BYTE;
        5'd1:        byte_c = PKT_ID;
        5'd2:        byte_c = SUB_ID;
        5'd3:        byte_c = LEN_SET[15:8];
        5'd4:        byte_c = LEN_SET[7:0];
        5'd5:        byte_c = MODE_SET;
        5'd6:        byte_c = tb_reg;
        5'd7:        byte_c = pb_reg;
        5'd8:        byte_c = mk_reg;
        5'd13:       byte_c = wd_reg[15:8];
        5'd14:       byte_c = wd_reg[7:0];
        5'd23:       byte_c = sum_reg;
        5'd25:       byte_c = END_BYTE;
        default:     byte_c = (idx_reg >= 5'd15 && idx_reg <= 5'd22) ?
                              of_reg[8*(22-idx_reg) +: 8] : 8'h00;
      endcase
    end
  end

  // sequencer: one byte per cycle, checksum accumulates id..payload
  always_comb begin
    act_next = act_reg;
    qry_next = qry_reg;
    idx_next = idx_reg;
    sum_next = sum_reg;
    v_next   = 1'b0;
    d_next   = 8'h00;
    if (!act_reg) begin
      if (req_query || req_set) begin
        act_next = 1'b1;
        qry_next = req_query;
        idx_next = 5'd0;
        sum_next = 8'h00;
      end
    end else begin
      v_next = 1'b1;
      d_next = byte_c;
      idx_next = idx_reg + 5'd1;
      if (idx_reg >= 5'd1 && idx_reg < last_idx - 5'd2)
        sum_next = sum_reg ^ byte_c;
      if (idx_reg == last_idx) act_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_reg <= 1'b0;
      qry_reg <= 1'b0;
      idx_reg <= 5'd0;
      sum_reg <= 8'h00;
      d_reg   <= 8'h00;
      v_reg   <= 1'b0;
      tb_reg  <= 8'h00;
      pb_reg  <= 8'h00;
      mk_reg  <= 8'h00;
      wd_reg  <= 16'h0;
      of_reg  <= 64'h0;
      rb_reg  <= 8'h00;
      rv_reg  <= 1'b0;
    end else begin
      act_reg <= act_next;
      qry_reg <= qry_next;
      idx_reg <= idx_next;
      sum_reg <= sum_next;
      d_reg   <= d_next;
      v_reg   <= v_next;
      rb_reg  <= link.d2h_data;
      rv_reg  <= link.d2h_valid;
      // fields latched at request so they hold during the frame
      if (!act_reg && req_set && !req_query) begin
        tb_reg <= set_time_base;
        pb_reg <= set_pulse_base;
        mk_reg <= set_pulse_mask;
        wd_reg <= set_width_ms;
        of_reg <= set_offset;
      end
    end
  end

  assign link.h2d_data  = d_reg;
  assign link.h2d_valid = v_reg;
  assign busy           = act_reg;
  assign resp_valid     = rv_reg;
  assign resp_byte      = rb_reg;
endmodule : tcfg_host

// ==== tcfg_checker.sv ====
// assertions on the link between the host end and the device end
`timescale 1ns/1ps
module tcfg_checker
  import tcfg_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // link signals
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_valid,
  input wire logic [7:0] d2h_data,
  input wire logic       d2h_valid
);
  logic [4:0] hc_reg, hc_next, dc_reg, dc_next;
  logic [7:0] hx_reg, hx_next, dx_reg, dx_next;

  // byte counts and running xor; start byte left out so a good frame ends at 10^03
  always_comb begin
    hc_next = h2d_valid ? hc_reg + 5'd1 : 5'd0;
    dc_next = d2h_valid ? dc_reg + 5'd1 : 5'd0;
    hx_next = (h2d_valid && hc_reg != 5'd0) ? hx_reg ^ h2d_data : 8'h00;
    dx_next = (d2h_valid && dc_reg != 5'd0) ? dx_reg ^ d2h_data : 8'h00;
  end

  // register the helpers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {hc_reg, dc_reg, hx_reg, dx_reg} <= '0;
    end else begin
      {hc_reg, dc_reg, hx_reg, dx_reg} <= {hc_next, dc_next, hx_next, dx_next};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_host_start: assert property (
    $rose(h2d_valid) |-> h2d_data == START_BYTE ##1 h2d_data == PKT_ID ##1 h2d_data == SUB_ID)
    else $error("host frame header wrong");
  a_resp_header: assert property (
    $rose(d2h_valid) |-> d2h_data == START_BYTE ##1 d2h_data == PKT_ID ##1 d2h_data == SUB_ID
      ##1 d2h_data == LEN_SET[15:8] ##1 d2h_data == LEN_SET[7:0] ##1 d2h_data == MODE_RESP)
    else $error("response header wrong");
  a_query_len: assert property (
    $rose(h2d_valid) ##5 h2d_data == MODE_QUERY
      |-> $past(h2d_data) == LEN_QUERY[7:0] ##3 h2d_valid ##1 !h2d_valid)
    else $error("query frame length wrong");
  a_set_len: assert property (
    $rose(h2d_valid) ##5 h2d_data == MODE_SET |-> ##20 h2d_valid ##1 !h2d_valid)
    else $error("set frame length wrong");
  a_resp_count: assert property ($fell(d2h_valid) |-> dc_reg == 5'd26)
    else $error("response not 26 bytes");
  a_host_tail: assert property (
    $fell(h2d_valid) |-> $past(h2d_data, 2) == START_BYTE && $past(h2d_data) == END_BYTE)
    else $error("host frame end wrong");
  a_resp_tail: assert property (
    $fell(d2h_valid) |-> $past(d2h_data, 2) == START_BYTE && $past(d2h_data) == END_BYTE)
    else $error("response end wrong");
  a_host_sum: assert property ($fell(h2d_valid) |-> hx_reg == 8'h13)
    else $error("host checksum wrong");
  a_resp_sum: assert property ($fell(d2h_valid) |-> dx_reg == 8'h13)
    else $error("response checksum wrong");
  a_answer_due: assert property ($fell(h2d_valid) |-> ##[1:8] $rose(d2h_valid))
    else $error("good frame not answered");
endmodule : tcfg_checker

// ==== tb_timing_config_packet_handler.sv ====
// testbench: host and device ends joined, plus a device on a lane driven raw
`timescale 1ns/1ps
module tb_timing_config_packet_handler
  import tcfg_pkg::*;
;
  logic             clk, rst, req_query, req_set, busy, resp_valid, frame_error, bad_err;
  logic             time_utc, pulse_utc, pulse_negative, even_two_second_pulse;
  logic [2:0]       time_constellation, pulse_constellation, pulse_mode;
  logic [7:0]       set_time_base, set_pulse_base, set_pulse_mask, resp_byte;
  logic [15:0]      set_width_ms, pulse_width_ms, bad_width, sw;
  logic [63:0]      set_offset, pulse_offset, so;
  logic [7:0]       rb [32];
  logic [7:0]       q [$];
  int               rn, bn, cyc, n_mismatch, cmp_count;

  tcfg_if link ();
  tcfg_if link_bad ();
  tcfg_host i_tcfg_host (.clk, .rst, .link(link.host), .req_query, .req_set, .set_time_base,
    .set_pulse_base, .set_pulse_mask, .set_width_ms, .set_offset, .busy, .resp_valid, .resp_byte);
  tcfg_device i_tcfg_device (.clk, .rst, .link(link.dev), .time_constellation, .time_utc,
    .pulse_constellation, .pulse_utc, .pulse_mode, .pulse_negative, .even_two_second_pulse,
    .pulse_width_ms, .pulse_offset, .frame_error);
  tcfg_device i_tcfg_device_bad (.clk, .rst, .link(link_bad.dev), .time_constellation(),
    .time_utc(), .pulse_constellation(), .pulse_utc(), .pulse_mode(), .pulse_negative(),
    .even_two_second_pulse(), .pulse_width_ms(bad_width), .pulse_offset(), .frame_error(bad_err));
  tcfg_checker i_tcfg_checker (.clk, .rst, .h2d_data(link.h2d_data), .h2d_valid(link.h2d_valid),
    .d2h_data(link.d2h_data), .d2h_valid(link.d2h_valid));

  // 100 mhz clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // capture echoed bytes, count answers on the raw lane, cut a hang short
  always @(posedge clk) begin
    if (resp_valid && rn < 32) begin
      rb[rn] = resp_byte;
      rn++;
    end
    if (link_bad.d2h_valid) bn++;
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // one host request; the whole answer is compared, then the applied settings
  task automatic run(input logic qry, input logic [7:0] tb_b, pb_b, mk_b,
                     input logic [15:0] w, input logic [63:0] ofs, eo);
    logic [0:25][7:0] e;
    int k;
    for (k = 0; k < 100 && busy !== 1'b0; k++) tick();
    {set_time_base, set_pulse_base, set_pulse_mask} = {tb_b, pb_b, mk_b};
    {set_width_ms, set_offset} = {w, ofs};
    {req_query, req_set} = {qry, !qry};
    rn = 0;
    tick();
    {req_query, req_set} = 2'b00;
    for (k = 0; k < 200 && rn < 26; k++) tick();
    e = {START_BYTE, PKT_ID, SUB_ID, LEN_SET, MODE_RESP, tb_b, pb_b, mk_b, 32'h0, w, eo,
         8'h00, START_BYTE, END_BYTE};
    for (k = 1; k < 23; k++) e[23] = e[23] ^ e[k];
    check(rn, 26, "answer length");
    for (k = 0; k < 26; k++) check(rb[k], e[k], "answer byte");
    check(time_constellation, tb_b[2:0], "time source");
    check(pulse_constellation, pb_b[2:0], "pulse source");
    check({time_utc, pulse_utc}, {tb_b[3], pb_b[3]}, "utc select");
    check(pulse_mode, mk_b[2:0], "pulse mode");
    check({even_two_second_pulse, pulse_negative}, mk_b[4:3], "polarity period");
    check(pulse_width_ms, w, "width");
    check(pulse_offset, eo, "offset");
    check(frame_error, 1'b0, "frame error");
  endtask : run

  // raw frame on the second lane; ck_flip spoils the checksum on purpose
  task automatic raw(input logic [7:0] sub, md, input logic [15:0] w,
                     input logic [63:0] ofs, input logic [7:0] ck_flip, input int ans);
    logic [7:0] ck;
    int k;
    q = {START_BYTE, PKT_ID, sub, 8'h00, (md == MODE_SET) ? 8'h13 : 8'h02, md};
    // reserved bytes set to all ones; the device drops them
    if (md == MODE_SET) q = {q, 8'h0b, 8'h04, 8'h1a, 8'hff, 8'hff, 8'hff, 8'hff};
    if (md == MODE_SET) q = {q, w[15:8], w[7:0]};
    if (md == MODE_SET) for (k = 7; k >= 0; k--) q.push_back(ofs[8*k +: 8]);
    ck = 8'h00;
    for (k = 1; k < q.size(); k++) ck = ck ^ q[k];
    q = {q, ck ^ ck_flip, START_BYTE, END_BYTE};
    bn = 0;
    foreach (q[i]) begin
      {link_bad.h2d_data, link_bad.h2d_valid} = {q[i], 1'b1};
      tick();
    end
    {link_bad.h2d_data, link_bad.h2d_valid} = {~END_BYTE, 1'b0};
    repeat (40) tick();
    check(bn, ans, "raw answer bytes");
    check(bad_err, ans == 0, "frame error flag");
    check(bad_width, 16'd300, "width after raw frame");
  endtask : raw

  initial begin
    {rst, req_query, req_set, set_time_base, set_pulse_base, set_pulse_mask} = {3'b100, 24'h0};
    {set_width_ms, set_offset, link_bad.h2d_data, link_bad.h2d_valid} = '0;
    {rn, bn, cyc, n_mismatch, cmp_count} = '0;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    tick();
    run(1'b1, RST_TBASE, RST_PBASE, RST_MASK, RST_WIDTH, 64'h0, 64'h0);
    $display("test reset query done");
    // every source, utc, pulse mode, polarity and period; width edges and offset zeroing
    for (int i = 0; i < 5; i++) begin
      sw = (i == 1 || i == 4) ? 16'd2 : WIDTH_MAX;
      so = (i == 2) ? MS_ONE : (i == 4) ? OFS_LIMIT : 64'h0;
      run(1'b0, {4'h0, i[0], i[2:0]}, {4'h0, ~i[0], 3'd4 - 3'(i)},
          {3'h0, i[2], i[0], 1'b0, i[1], i[0] | i[2]}, sw, so, (i == 4) ? 64'h0 : so);
    end
    $display("test set sweep done");
    run(1'b1, 8'h04, 8'h08, 8'h11, 16'd2, 64'h0, 64'h0);
    $display("test settings query done");
    raw(SUB_ID, MODE_SET, 16'd300, 64'h0, 8'h00, 26);
    raw(SUB_ID, MODE_SET, 16'd300, 64'h0, 8'h01, 0);
    raw(SUB_ID, MODE_SET, 16'd1, 64'h0, 8'h00, 0);
    raw(SUB_ID, MODE_SET, 16'd501, 64'h0, 8'h00, 0);
    raw(SUB_ID, MODE_SET, 16'd300, 64'h3fd0000000000001, 8'h00, 0);
    raw(SUB_ID, MODE_SET, 16'd300, 64'hbfd0000000000001, 8'h00, 0);
    raw(8'h04, MODE_QUERY, 16'd0, 64'h0, 8'h00, 0);
    raw(SUB_ID, MODE_RESP, 16'd0, 64'h0, 8'h00, 0);
    raw(SUB_ID, MODE_QUERY, 16'd0, 64'h0, 8'h00, 26);
    $display("test raw lane done");
    wrap_up();
  end
endmodule : tb_timing_config_packet_handler
